// ### rtl/sensor_spi_cmd.sv
`timescale 1ns/1ps
`default_nettype none
`include "sensor_spi_map.svh"
// Functional notes
// - command bit 15 high means acceleration data request
// - channel and offset select bits pick X/Y, offset-cancelled or raw
// - signed bit checked against config bit 4, trigger bit against config bits 2|1
// - config mismatch flags failure and withholds acceleration data
// - acceleration commands carry odd parity, checked by device
// - valid acceleration answer only with no flag or error pending
// - bit 15 low is register access; select bit 0 read, 1 write
// - register commands carry odd parity, checked by device
// - write carries address in bits 12..8, data in bits 7..0
// - write answer normal only without errors; lock exempts control register
// - write applied after frame ends, dropped on SPI error
// - read carries address in bits 12..8, bits 7..0 zero
// - read answer normal only without SPI, readback or invalid errors
// - exceptions answered by priority; 1-7 block trigger, 4-5 disable pulse code
// - offset and sigma-delta over range affect no output
// - SPI error on clock level, edge count, parity or nonzero fields
// - SPI error answers error word, blocks trigger, spares pulse code
// - every driven MISO bit read back; mismatch sets readback fault
// - readback fault drops acceleration request, answers MISO error
// - readback fault still performs a write that would have been valid, answers MISO error
// - readback fault drops read; status clear-on-read suppressed
// - readback fault held until clean status read
module sensor_spi_cmd (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   input wire logic miso_readback,
   input wire sensor_spi_pkg::dev_flags_t dev_flags,
   input wire logic offset_over_range,
   input wire logic sigma_delta_over_range,
   input wire logic [9:0] accel_data,
   output logic miso_out,
   output logic miso_oe,
   output logic [2:0] channel_sel,
   output logic trigger_update,
   output logic pulse_code_enable,
   output logic [7:0] config_register,
   output logic [7:0] control_register,
   output logic status_clear,
   output logic readback_fault_flag
);
   logic [2:0] pins;
   logic sclk_s;
   logic cs_n_s;
   logic mosi_s;
   pin_sync u_sync (
      .clock(clock),
      .arst_n(arst_n),
      .pin_in({sclk, mosi, cs_n}),
      .pin_out(pins)
   );
   // sync resets to 3'h1: chip select must come out of reset idle high
   assign {sclk_s, mosi_s, cs_n_s} = pins;

   // readback is a pin too; own two-stage sync, first stage read only by second
   logic rb_meta_ff, rb_sync_ff;
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rb_meta_ff <= 1'b0;
         rb_sync_ff <= 1'b0;
      end else begin
         rb_meta_ff <= miso_readback;
         rb_sync_ff <= rb_meta_ff;
      end
   end

   function automatic logic is_readable(input logic [4:0] a);
      is_readable = (a <= `ADDR_LAST);
   endfunction : is_readable
   function automatic logic is_writable(input logic [4:0] a);
      is_writable = (a == `ADDR_CONFIG) || (a == `ADDR_CONTROL);
   endfunction : is_writable

   sensor_spi_pkg::frame_state_t state_ff, nxt_state;
   logic sclk_d_ff, nxt_sclk_d;
   logic [15:0] rx_ff, nxt_rx;
   logic [15:0] tx_ff, nxt_tx;
   logic [15:0] rsp_ff, nxt_rsp;
   logic [4:0] edges_ff, nxt_edges;
   logic timing_err_ff, nxt_timing_err;
   logic frame_rb_err_ff, nxt_frame_rb_err;
   logic miso_ff, nxt_miso;
   logic oe_ff, nxt_oe;
   logic [2:0] chan_ff, nxt_chan;
   logic trig_ff, nxt_trig;
   logic pcm_ff, nxt_pcm;
   logic [7:0] cfg_ff, nxt_cfg;
   logic [7:0] ctl_ff, nxt_ctl;
   logic clr_ff, nxt_clr;
   logic rbf_ff, nxt_rbf;

   wire sclk_rise = sclk_s && !sclk_d_ff;
   wire sclk_fall = !sclk_s && sclk_d_ff;

   // frame decode, used when cs_n rises
   logic [15:0] cmd;
   logic is_accel, is_write, parity_ok, spi_err, invalid_reg, mismatch, miso_err;
   logic cfg_lock;
   logic [4:0] addr;
   always_comb begin
      cmd = rx_ff;
      addr = cmd[`CMD_ADDR_HI:`CMD_ADDR_LO];
      is_accel = cmd[`CMD_ACCEL_BIT];
      is_write = !is_accel && cmd[`CMD_SELECT_BIT];
      parity_ok = ^cmd;
      cfg_lock = cfg_ff[`CFG_LOCK_BIT];
      spi_err = timing_err_ff || sclk_s || (edges_ff != `FRAME_BITS) || !parity_ok;
      if (is_accel && (cmd[`CMD_ZERO_HI:`CMD_ZERO_LO] != 8'h00)) begin
         spi_err = 1'b1;
      end
      if (!is_accel && !is_write && (cmd[`CMD_DATA_HI:`CMD_DATA_LO] != 8'h00)) begin
         spi_err = 1'b1;
      end
      mismatch = is_accel && ((cmd[`CMD_SIGNED_BIT] != cfg_ff[`CFG_SIGNED_BIT]) ||
         (cmd[`CMD_TRIG_BIT] != (cfg_ff[`CFG_TRIG_HI_BIT] | cfg_ff[`CFG_TRIG_LO_BIT])));
      invalid_reg = 1'b0;
      if (!is_accel && is_write) begin
         invalid_reg = !is_writable(addr) || (cfg_lock && addr != `ADDR_CONTROL);
      end else if (!is_accel) begin
         invalid_reg = !is_readable(addr);
      end
      miso_err = frame_rb_err_ff || (oe_ff && (rb_sync_ff != miso_ff));
   end

   always_comb begin
      nxt_state = state_ff;
      nxt_sclk_d = sclk_s;
      nxt_rx = rx_ff;
      nxt_tx = tx_ff;
      nxt_rsp = rsp_ff;
      nxt_edges = edges_ff;
      nxt_timing_err = timing_err_ff;
      nxt_frame_rb_err = frame_rb_err_ff;
      nxt_miso = miso_ff;
      nxt_oe = oe_ff;
      nxt_chan = chan_ff;
      nxt_trig = 1'b0;
      nxt_pcm = !(dev_flags.init_pending || dev_flags.reset_occurred);
      nxt_cfg = cfg_ff;
      nxt_ctl = ctl_ff;
      nxt_clr = 1'b0;
      nxt_rbf = rbf_ff;
      case (state_ff)
         sensor_spi_pkg::ST_IDLE: begin
            nxt_oe = 1'b0;
            if (!cs_n_s) begin
               nxt_state = sensor_spi_pkg::ST_SHIFT;
               nxt_timing_err = sclk_s;
               nxt_edges = 5'h00;
               nxt_frame_rb_err = 1'b0;
               nxt_tx = {rsp_ff[14:0], 1'b0};
               nxt_miso = rsp_ff[15];
               nxt_oe = 1'b1;
            end
         end
         sensor_spi_pkg::ST_SHIFT: begin
            if (sclk_rise) begin
               nxt_rx = {rx_ff[14:0], mosi_s};
               nxt_edges = (edges_ff == 5'h1F) ? edges_ff : edges_ff + 5'h01;
               // bit driven was settled for half a period; compare now
               if (rb_sync_ff != miso_ff) begin
                  nxt_frame_rb_err = 1'b1;
               end
            end
            if (sclk_fall) begin
               nxt_miso = tx_ff[15];
               nxt_tx = {tx_ff[14:0], 1'b0};
            end
            if (cs_n_s) begin
               nxt_state = sensor_spi_pkg::ST_END;
               nxt_oe = 1'b0;
            end
         end
         sensor_spi_pkg::ST_END: begin
            nxt_state = sensor_spi_pkg::ST_IDLE;
            if (miso_err) begin
               nxt_rbf = 1'b1;
            end
            // priority: spi, readback, invalid, flags, then normal
            if (spi_err) begin
               nxt_rsp = `RSP_SPI_ERR;
            end else if (miso_err) begin
               nxt_rsp = `RSP_MISO_ERR;
               // only a write that would have been valid is carried out
               if (is_write && !invalid_reg) begin
                  nxt_cfg = (addr == `ADDR_CONFIG) ? cmd[7:0] : cfg_ff;
                  nxt_ctl = (addr == `ADDR_CONTROL) ? cmd[7:0] : ctl_ff;
               end
            end else if (is_accel) begin
               if (mismatch) begin
                  nxt_rsp = `RSP_INVALID_ACC;
               end else if (dev_flags.init_pending || dev_flags.reset_occurred ||
                            dev_flags.crc_fault || dev_flags.internal_fault) begin
                  nxt_rsp = `RSP_INTERNAL;
               end else if (dev_flags.selftest_fault) begin
                  nxt_rsp = `RSP_SELFTEST;
               end else begin
                  // over range flags deliberately unused here
                  nxt_rsp = {4'h8, 2'b00, accel_data};
                  nxt_trig = 1'b1;
                  nxt_chan = {1'b0, cmd[`CMD_SELECT_BIT], cmd[`CMD_OFFSET_BIT]};
               end
            end else if (invalid_reg) begin
               nxt_rsp = `RSP_INVALID_REG;
            end else if (is_write) begin
               nxt_rsp = `RSP_WRITE_OK | {8'h00, cmd[7:0]};
               nxt_cfg = (addr == `ADDR_CONFIG) ? cmd[7:0] : cfg_ff;
               nxt_ctl = (addr == `ADDR_CONTROL) ? cmd[7:0] : ctl_ff;
            end else begin
               if (addr == `ADDR_CONFIG) begin
                  nxt_rsp = `RSP_READ_OK | {8'h00, cfg_ff};
               end else if (addr == `ADDR_CONTROL) begin
                  nxt_rsp = `RSP_READ_OK | {8'h00, ctl_ff};
               end else begin
                  nxt_rsp = `RSP_READ_OK | {8'h00, 1'b0, rbf_ff, 6'h00};
                  nxt_clr = 1'b1;
                  nxt_rbf = 1'b0;
               end
            end
         end
         default: begin
            nxt_state = sensor_spi_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state_ff <= sensor_spi_pkg::ST_IDLE;
         sclk_d_ff <= 1'b0;
         rx_ff <= 16'h0000;
         tx_ff <= 16'h0000;
         rsp_ff <= `RSP_SPI_ERR;
         edges_ff <= 5'h00;
         timing_err_ff <= 1'b0;
         frame_rb_err_ff <= 1'b0;
         miso_ff <= 1'b0;
         oe_ff <= 1'b0;
         chan_ff <= sensor_spi_pkg::CH_NONE;
         trig_ff <= 1'b0;
         pcm_ff <= 1'b0;
         cfg_ff <= `CFG_RESET_VAL;
         ctl_ff <= 8'h00;
         clr_ff <= 1'b0;
         rbf_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         sclk_d_ff <= nxt_sclk_d;
         rx_ff <= nxt_rx;
         tx_ff <= nxt_tx;
         rsp_ff <= nxt_rsp;
         edges_ff <= nxt_edges;
         timing_err_ff <= nxt_timing_err;
         frame_rb_err_ff <= nxt_frame_rb_err;
         miso_ff <= nxt_miso;
         oe_ff <= nxt_oe;
         chan_ff <= nxt_chan;
         trig_ff <= nxt_trig;
         pcm_ff <= nxt_pcm;
         cfg_ff <= nxt_cfg;
         ctl_ff <= nxt_ctl;
         clr_ff <= nxt_clr;
         rbf_ff <= nxt_rbf;
      end
   end

   assign miso_out = miso_ff;
   assign miso_oe = oe_ff;
   assign channel_sel = chan_ff;
   assign trigger_update = trig_ff;
   assign pulse_code_enable = pcm_ff;
   assign config_register = cfg_ff;
   assign control_register = ctl_ff;
   assign status_clear = clr_ff;
   assign readback_fault_flag = rbf_ff;

   wire at_end = (state_ff == sensor_spi_pkg::ST_END);
   sequence frame_close_s;
      at_end && spi_err;
   endsequence
   spi_err_rsp_a: assert property (@(posedge clock) disable iff (!arst_n)
      frame_close_s |=> (rsp_ff == `RSP_SPI_ERR) && !trigger_update)
      else $error("spi error not answered");
   miso_rsp_a: assert property (@(posedge clock) disable iff (!arst_n)
      at_end && !spi_err && miso_err |=> rsp_ff == `RSP_MISO_ERR && !trigger_update)
      else $error("readback fault not answered");
   rbf_set_a: assert property (@(posedge clock) disable iff (!arst_n)
      at_end && miso_err |=> readback_fault_flag)
      else $error("readback fault flag not set");
   rbf_hold_a: assert property (@(posedge clock) disable iff (!arst_n)
      $fell(readback_fault_flag) |-> status_clear)
      else $error("readback flag cleared without status read");
   mismatch_a: assert property (@(posedge clock) disable iff (!arst_n)
      at_end && !spi_err && !miso_err && mismatch |=> rsp_ff == `RSP_INVALID_ACC)
      else $error("mismatch not answered");
   write_drop_a: assert property (@(posedge clock) disable iff (!arst_n)
      at_end && spi_err |=> $stable(config_register) && $stable(control_register))
      else $error("write applied despite spi error");
   pcm_off_a: assert property (@(posedge clock) disable iff (!arst_n)
      dev_flags.init_pending |=> !pulse_code_enable)
      else $error("pulse code not disabled");
   trig_cause_a: assert property (@(posedge clock) disable iff (!arst_n)
      trigger_update |-> $past(at_end) && rsp_ff[15])
      else $error("trigger without valid acceleration answer");
endmodule : sensor_spi_cmd
`default_nettype wire

// ### rtl/sensor_spi_map.svh
`ifndef SENSOR_SPI_MAP_SVH
`define SENSOR_SPI_MAP_SVH
// command word fields
`define CMD_ACCEL_BIT 15
`define CMD_SELECT_BIT 14
`define CMD_OFFSET_BIT 13
`define CMD_ADDR_HI 12
`define CMD_ADDR_LO 8
`define CMD_DATA_HI 7
`define CMD_DATA_LO 0
`define CMD_SIGNED_BIT 12
`define CMD_TRIG_BIT 11
`define CMD_ZERO_HI 10
`define CMD_ZERO_LO 3
`define FRAME_BITS 5'h10
// config register fields
`define CFG_SIGNED_BIT 4
`define CFG_TRIG_HI_BIT 2
`define CFG_TRIG_LO_BIT 1
`define CFG_RESET_VAL 8'h00
`define CFG_LOCK_BIT 0
// register addresses
`define ADDR_CONFIG 5'h00
`define ADDR_CONTROL 5'h01
`define ADDR_STATUS 5'h02
`define ADDR_LAST 5'h02
// status register bit of the readback fault
`define STAT_READBACK_BIT 6
// response words
`define RSP_SPI_ERR 16'h1F00
`define RSP_MISO_ERR 16'h0C00
`define RSP_INVALID_REG 16'h0E00
`define RSP_INVALID_ACC 16'h0800
`define RSP_INTERNAL 16'h0900
`define RSP_SELFTEST 16'h2C00
`define RSP_WRITE_OK 16'h4000
`define RSP_READ_OK 16'h0000
`endif

// ### rtl/sensor_spi_pkg.sv
package sensor_spi_pkg;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SHIFT = 2'b01,
      ST_END = 2'b11
   } frame_state_t;
   typedef enum logic [2:0] {
      CH_X_CANCEL = 3'h0,
      CH_X_RAW = 3'h1,
      CH_Y_CANCEL = 3'h2,
      CH_Y_RAW = 3'h3,
      CH_NONE = 3'h4
   } channel_t;
   typedef struct packed {
      logic [4:0] addr;
      logic [7:0] data;
      logic valid;
   } reg_write_t;
   typedef struct packed {
      logic init_pending;
      logic reset_occurred;
      logic internal_fault;
      logic selftest_fault;
      logic crc_fault;
   } dev_flags_t;
endpackage : sensor_spi_pkg

// ### rtl/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic [2:0] pin_in,
   output logic [2:0] pin_out
);
   logic [2:0] meta_ff;
   logic [2:0] sync_ff;
   logic [2:0] nxt_meta;
   logic [2:0] nxt_sync;
   always_comb begin
      nxt_meta = pin_in;
      nxt_sync = meta_ff;
   end
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         meta_ff <= 3'h1;
         sync_ff <= 3'h1;
      end else begin
         meta_ff <= nxt_meta;
         sync_ff <= nxt_sync;
      end
   end
   assign pin_out = sync_ff;
endmodule : pin_sync
`default_nettype wire

// ### verification/spi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
   input wire logic clock,
   input wire logic miso,
   output logic sclk,
   output logic cs_n,
   output logic mosi
);
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : tick
   // serial clock idles low between frames
   task automatic frame(input logic [15:0] cmd, input int edges, input logic hi,
      output logic [15:0] rsp);
      tick(1);
      sclk = hi;
      cs_n = 1'b0;
      tick(4);
      sclk = 1'b0;
      for (int i = 0; i < edges; i++) begin
         mosi = cmd[15 - (i % 16)];
         tick(4);
         sclk = 1'b1;
         rsp = {rsp[14:0], miso};
         tick(4);
         sclk = 1'b0;
      end
      tick(4);
      cs_n = 1'b1;
      // released data line must not look like a held bit
      mosi = ~mosi;
      tick(8);
   endtask : frame
endmodule : spi_host_model
`default_nettype wire

// ### verification/test_sensor_spi_command_exception_logic.sv
`timescale 1ns/1ps
`default_nettype none
`include "sensor_spi_map.svh"
module test_sensor_spi_command_exception_logic;
   logic clock = 1'b0;
   logic arst_n = 1'b0;
   logic sclk, cs_n, mosi, miso_out, miso_oe, miso_wire;
   logic corrupt = 1'b0;
   logic ovr = 1'b0;
   sensor_spi_pkg::dev_flags_t dev_flags = '0;
   logic [9:0] accel_data = 10'h2A5;
   logic [2:0] channel_sel;
   logic trigger_update, pulse_code_enable, status_clear, readback_fault_flag;
   logic [7:0] config_register, control_register;
   logic [15:0] valid_rsp;
   logic [15:0] fexp [5] = '{16'h0900, 16'h0900, 16'h0900, 16'h2C00, 16'h0900};
   int err_count = 0;
   int comparisons = 0;
   int trig_cnt = 0;
   int clr_cnt = 0;
   int n, c;
   always #5 clock = ~clock;
   // undriven wire reads back the inverse of the last level
   assign miso_wire = miso_oe ? miso_out ^ corrupt : ~miso_out;
   assign valid_rsp = {6'h20, accel_data};
   always @(posedge clock) begin
      if (trigger_update === 1'b1) trig_cnt++;
      if (status_clear === 1'b1) clr_cnt++;
   end
   spi_host_model host (.clock(clock), .miso(miso_wire), .sclk(sclk), .cs_n(cs_n),
      .mosi(mosi));
   sensor_spi_cmd dut (.clock(clock), .arst_n(arst_n), .sclk(sclk), .cs_n(cs_n),
      .mosi(mosi), .miso_readback(miso_wire), .dev_flags(dev_flags),
      .offset_over_range(ovr), .sigma_delta_over_range(ovr),
      .accel_data(accel_data), .miso_out(miso_out), .miso_oe(miso_oe),
      .channel_sel(channel_sel), .trigger_update(trigger_update),
      .pulse_code_enable(pulse_code_enable), .config_register(config_register),
      .control_register(control_register), .status_clear(status_clear),
      .readback_fault_flag(readback_fault_flag));
   task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: word %h, expected %h", $time, got, exp);
      end
   endtask : cmp_word
   task automatic cmp_bits(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: value %h, expected %h", $time, got, exp);
      end
   endtask : cmp_bits
   task automatic final_report;
      if (err_count == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : final_report
   function automatic logic [15:0] odd(input logic [15:0] w, input logic [15:0] p);
      return (^w) ? w : w | p;
   endfunction : odd
   function automatic logic [15:0] rc(input logic wr, input logic [4:0] a,
      input logic [7:0] d);
      return odd({1'b0, wr, 1'b0, a, d}, 16'h2000);
   endfunction : rc
   function automatic logic [15:0] ac(input logic s, input logic o, input logic sg,
      input logic tr);
      return odd({1'b1, s, o, sg, tr, 11'h000}, 16'h0001);
   endfunction : ac
   // a frame carries the answer to the command before it
   task automatic xfer(input logic [15:0] cmd, input logic [15:0] exp,
      input int edges = 16, input logic hi = 1'b0);
      logic [15:0] rsp;
      host.frame(cmd, edges, hi, rsp);
      // a corrupted line inverts every bit the host sees
      if (edges == 16 && !hi) cmp_word(corrupt ? ~rsp : rsp, exp);
   endtask : xfer
   initial begin
      repeat (60000) @(posedge clock);
      err_count++;
      final_report();
   end
   initial begin
      repeat (4) @(posedge clock);
      #1 arst_n = 1'b1;
      repeat (4) @(posedge clock);
      xfer(rc(1'b0, `ADDR_CONFIG, 8'h00), `RSP_SPI_ERR);
      xfer(rc(1'b1, `ADDR_CONFIG, 8'h10), `RSP_READ_OK);
      xfer(rc(1'b0, `ADDR_CONFIG, 8'h00), `RSP_WRITE_OK | 16'h0010);
      cmp_bits(config_register, 8'h10);
      cmp_bits({7'h00, miso_oe}, 8'h00);
      for (int i = 0; i < 4; i++) begin
         n = trig_cnt;
         xfer(ac(i[1], i[0], 1'b1, 1'b0), i == 0 ? 16'h0010 : valid_rsp);
         cmp_bits({5'h00, channel_sel}, 8'(i));
         cmp_bits(8'(trig_cnt - n), 8'h01);
      end
      n = trig_cnt;
      xfer(ac(1'b0, 1'b0, 1'b0, 1'b0), valid_rsp);
      xfer(ac(1'b0, 1'b0, 1'b1, 1'b1), `RSP_INVALID_ACC);
      xfer(ac(1'b0, 1'b0, 1'b1, 1'b0) ^ 16'h0001, `RSP_INVALID_ACC);
      xfer(16'h9008, `RSP_SPI_ERR);
      xfer(rc(1'b0, `ADDR_CONFIG, 8'h01), `RSP_SPI_ERR);
      xfer(rc(1'b1, `ADDR_CONTROL, 8'h5A) ^ 16'h2000, `RSP_SPI_ERR);
      xfer(rc(1'b0, `ADDR_CONFIG, 8'h00), `RSP_SPI_ERR);
      // cut and early-clock frames lose their own capture; the next frame checks them
      xfer(rc(1'b0, `ADDR_CONFIG, 8'h00), 16'h0010, 15);
      xfer(rc(1'b0, `ADDR_CONFIG, 8'h00), `RSP_SPI_ERR);
      xfer(rc(1'b0, `ADDR_CONFIG, 8'h00), 16'h0010, 16, 1'b1);
      xfer(rc(1'b0, 5'h03, 8'h00), `RSP_SPI_ERR);
      cmp_bits(control_register, 8'h00);
      xfer(rc(1'b1, `ADDR_STATUS, 8'h01), `RSP_INVALID_REG);
      xfer(rc(1'b1, `ADDR_CONFIG, 8'h11), `RSP_INVALID_REG);
      xfer(rc(1'b1, `ADDR_CONFIG, 8'h10), `RSP_WRITE_OK | 16'h0011);
      xfer(rc(1'b1, `ADDR_CONTROL, 8'h5A), `RSP_INVALID_REG);
      cmp_bits(config_register, 8'h11);
      cmp_bits(control_register, 8'h5A);
      cmp_bits(8'(trig_cnt - n), 8'h00);
      corrupt = 1'b1;
      xfer(rc(1'b1, `ADDR_CONTROL, 8'h33), `RSP_WRITE_OK | 16'h005A);
      cmp_bits(control_register, 8'h33);
      cmp_bits({7'h00, readback_fault_flag}, 8'h01);
      c = clr_cnt;
      xfer(rc(1'b0, `ADDR_STATUS, 8'h00), `RSP_MISO_ERR);
      xfer(ac(1'b0, 1'b0, 1'b1, 1'b0), `RSP_MISO_ERR);
      corrupt = 1'b0;
      cmp_bits(8'(clr_cnt - c), 8'h00);
      cmp_bits({7'h00, readback_fault_flag}, 8'h01);
      cmp_bits(8'(trig_cnt - n), 8'h00);
      xfer(rc(1'b0, `ADDR_STATUS, 8'h00), `RSP_MISO_ERR);
      xfer(rc(1'b0, `ADDR_CONFIG, 8'h00), 16'h0040);
      cmp_bits(8'(clr_cnt - c), 8'h01);
      cmp_bits({7'h00, readback_fault_flag}, 8'h00);
      for (int i = 0; i < 5; i++) begin
         dev_flags = sensor_spi_pkg::dev_flags_t'(5'h10 >> i);
         xfer(ac(1'b0, 1'b0, 1'b1, 1'b0), 16'h0011);
         xfer(rc(1'b0, `ADDR_CONFIG, 8'h00), fexp[i]);
         cmp_bits({7'h00, pulse_code_enable}, i < 2 ? 8'h00 : 8'h01);
      end
      cmp_bits(8'(trig_cnt - n), 8'h00);
      dev_flags = '0;
      ovr = 1'b1;
      xfer(ac(1'b0, 1'b0, 1'b1, 1'b0), 16'h0011);
      xfer(rc(1'b0, `ADDR_CONFIG, 8'h00), valid_rsp);
      cmp_bits(8'(trig_cnt - n), 8'h01);
      cmp_bits({7'h00, pulse_code_enable}, 8'h01);
      final_report();
   end
endmodule : test_sensor_spi_command_exception_logic
`default_nettype wire
